// file: lic_core.sv
`timescale 1ns/100ps
`default_nettype none
module lic_core
    import lic_pkg::*;
#(
    parameter logic [7:0] LIC_VERSION = 8'h15 // Arbitrary version code
) (
    input wire logic clk, // Core clock, 20 MHz
    input wire logic rst_n, // Hardware reset, active low
    input wire logic ce, // Clock enable
    input wire logic [7:0] id_pins, // Controller ID straps
    input wire logic boot_strap, // Boot processor strap
    input wire logic controller_strap_pin, // Controller present strap
    input wire logic bus_gen_new, // Newer system bus strap
    input wire logic init_pin_n, // Init pin, active low
    input wire logic stop_clock_pin_n, // Stop-clock pin, active low
    input wire logic local_int_pin_0, // Local interrupt pin 0
    input wire logic local_int_pin_1, // Local interrupt pin 1
    input wire logic phys_leaf_sup, // Width leaf supported
    input wire logic [7:0] phys_leaf_width, // Width from that leaf
    input wire logic msr_wr, // Model register write
    input wire logic msr_rd, // Model register read
    input wire logic [31:0] msr_addr, // Model register address
    input wire logic [63:0] msr_wdata, // Model register write data
    output logic [63:0] msr_rdata, // Model register read data
    output logic msr_ack, // Access done pulse
    output logic msr_fault, // Access refused pulse
    input wire logic mem_req, // Memory access request
    input wire logic mem_we, // Memory write
    input wire logic [35:0] mem_addr, // Physical address
    input wire logic [31:0] mem_wdata, // Memory write data
    output logic mem_hit, // Address claimed
    output logic [31:0] mem_rdata, // Memory read data
    output logic mem_rvalid, // Read data valid pulse
    input wire logic accept_wr, // Vector word update
    input wire logic [4:0] accept_idx, // Vector word index
    input wire logic [31:0] accept_data, // Vector word value
    input wire logic init_msg, // Init message pulse
    input wire logic nmi_msg, // Non-maskable message pulse
    input wire logic startup_msg, // Startup message pulse
    input wire logic therm_evt, // Thermal sensor event
    input wire logic perf_evt, // Performance counter event
    input wire logic err_evt, // Internal error event
    output logic [5:0] lvt_deliver, // Per-source delivery pulse
    output logic core_init, // Init to core pulse
    output logic core_nmi, // NMI to core pulse
    output logic core_startup, // Startup to core pulse
    output logic core_stop_clock, // Stop-clock to core level
    output logic [31:0] ident_feature_edx, // Leaf 1 feature flags
    output logic [7:0] ident_initial_id, // Leaf 1 initial ID
    output logic [7:0] arbitration_id_reg // Arbitration ID
);
    logic [14:0] sync_q;
    wire [7:0] id_s = sync_q[14:7];
    wire boot_s = sync_q[6];
    wire strap_s = sync_q[5];
    wire gen_s = sync_q[4];
    wire init_s = sync_q[3];
    wire stop_s = sync_q[2];
    wire local_int_pin_0_s = sync_q[1];
    wire local_int_pin_1_s = sync_q[0];

    lic_sync #(.W(15)) u_sync (
        .clk(clk),
        .ce(ce),
        .d({id_pins, boot_strap, controller_strap_pin, bus_gen_new,
            init_pin_n, stop_clock_pin_n, local_int_pin_0, local_int_pin_1}),
        .q(sync_q)
    );

    lic_phase_e phase_r;
    logic en_r, locked_r, bsp_r, gen_new_r, init_prev_r;
    logic [23:0] base_r;
    logic [7:0] id_r, init_id_r, arb_r, tpr_r, ldr_r;
    logic [3:0] dfr_r, tdiv_r;
    logic [8:0] svr_r;
    logic [31:0] icr_lo_r, icr_hi_r, tinit_r, tcur_r, reg_rdata_r;
    logic [16:0] lvt_r [0:LIC_LVT_N-1];
    logic vec_rd_r;
    logic [31:0] vec_rdata;

    // Decode of the model-register port
    wire run = (phase_r == LIC_PH_RUN);
    wire [7:0] phys_w = phys_leaf_sup ? phys_leaf_width : LIC_PHYS_WIDTH_DFLT;
    wire [63:0] rsvd = lic_rsvd_mask(phys_w);
    wire msr_here = (msr_addr == LIC_BASE_MSR_ADDR);
    wire msr_rsvd_set = |(msr_wdata & rsvd);
    wire msr_ok_wr = run && msr_wr && msr_here && !msr_rsvd_set;
    wire msr_bad = run && (msr_wr || msr_rd) && (!msr_here || (msr_wr && msr_rsvd_set));
    wire en_req = msr_wdata[LIC_EN_BIT];
    // An older bus loses arbitration state, so enable cannot return
    wire en_wr_val = en_req && !locked_r;
    wire gdis_evt = msr_ok_wr && en_r && !en_req;

    // Init reset from message or pin edge
    wire init_fall = init_prev_r && !init_s;
    wire init_evt = run && en_r && (init_msg || init_fall);
    wire local_clr = init_evt || gdis_evt;

    // Register block decode against the relocatable base
    wire blk_hit = run && mem_req && en_r && (mem_addr[35:12] == base_r);
    wire [11:0] off = {mem_addr[11:4], 4'h0};
    wire reg_wr = blk_hit && mem_we && !local_clr;
    wire reg_rd = blk_hit && !mem_we;
    wire lvt_hit = (off >= LIC_OFF_LVT_FIRST) && (off <= LIC_OFF_LVT_LAST);
    wire [2:0] lvt_idx = off[6:4] - LIC_LVT_IDX_BIAS;
    wire vec_hit = (off >= LIC_OFF_VEC_FIRST) && (off < LIC_OFF_VEC_END);
    wire [4:0] vec_idx = off[8:4] - LIC_VEC_IDX_BIAS;
    wire sw_en = svr_r[LIC_SVR_EN_BIT];
    wire svr_wr = reg_wr && (off == LIC_OFF_SVR);
    wire soft_dis_evt = svr_wr && !mem_wdata[LIC_SVR_EN_BIT];
    wire timer_evt = (tcur_r == 32'h0000_0001);

    // Source order follows the vector table: timer, thermal, perf, pin 0, pin 1, error
    wire [5:0] lvt_src = {err_evt, local_int_pin_1_s, local_int_pin_0_s, perf_evt, therm_evt, timer_evt};
    // Thermal and perf pass this gate under a locked global disable, but that disable sets every mask, so none is delivered
    wire [5:0] lvt_allow = en_r ? 6'h3f : (locked_r ? LIC_LVT_LOCKED_OK : 6'h00);
    logic [5:0] lvt_open;
    always_comb
    begin
        for (int i = 0; i < LIC_LVT_N; i++)
            lvt_open[i] = !lvt_r[i][LIC_LVT_MASK_BIT];
    end

    logic [31:0] rd_val;
    always_comb
    begin
        rd_val = 32'h0000_0000;
        case (off)
            LIC_OFF_ID: rd_val = {id_r, 24'h00_0000};
            LIC_OFF_VER: rd_val = {8'h00, LIC_MAX_LVT, 8'h00, LIC_VERSION};
            LIC_OFF_TPR: rd_val = {24'h00_0000, tpr_r};
            LIC_OFF_LDR: rd_val = {ldr_r, 24'h00_0000};
            LIC_OFF_DFR: rd_val = {dfr_r, LIC_DFR_RO_ONES};
            LIC_OFF_SVR: rd_val = {23'h00_0000, svr_r};
            LIC_OFF_ICR_LO: rd_val = icr_lo_r;
            LIC_OFF_ICR_HI: rd_val = icr_hi_r;
            LIC_OFF_TINIT: rd_val = tinit_r;
            LIC_OFF_TCUR: rd_val = tcur_r;
            LIC_OFF_TDIV: rd_val = {28'h000_0000, tdiv_r};
            default:
            begin
                if (lvt_hit)
                    rd_val = {15'h0000, lvt_r[lvt_idx]};
            end
        endcase
    end

    lic_vec_mem u_vec (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .clr(local_clr),
        .wr_en(accept_wr && run),
        .wr_idx(accept_idx),
        .wr_data(accept_data),
        .rd_idx(vec_idx),
        .rd_data(vec_rdata)
    );

    // Straps and global state; one write updates base and enable together
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            phase_r <= LIC_PH_CAPTURE;
            en_r <= 1'b0;
            locked_r <= 1'b0;
            bsp_r <= 1'b0;
            gen_new_r <= 1'b0;
            base_r <= LIC_BASE_RST;
            id_r <= 8'h00;
            init_id_r <= 8'h00;
            arb_r <= 8'h00;
        end
        else if (ce)
        begin
            case (phase_r)
                LIC_PH_CAPTURE:
                begin
                    id_r <= id_s & lic_id_mask(gen_s);
                    init_id_r <= id_s & lic_id_mask(gen_s);
                    arb_r <= id_s & lic_id_mask(gen_s);
                    bsp_r <= boot_s;
                    gen_new_r <= gen_s;
                    en_r <= strap_s;
                    phase_r <= LIC_PH_RUN;
                end
                LIC_PH_RUN:
                begin
                    if (msr_ok_wr)
                    begin
                        en_r <= en_wr_val;
                        base_r <= msr_wdata[LIC_BASE_MSB:LIC_BASE_LSB];
                    end
                    if (gdis_evt && !gen_new_r)
                        locked_r <= 1'b1;
                    // Model-dependent write; software is advised to leave it alone
                    if (reg_wr && (off == LIC_OFF_ID))
                        id_r <= mem_wdata[31:LIC_ID_LSB] & lic_id_mask(gen_new_r);
                end
                default: phase_r <= LIC_PH_CAPTURE;
            endcase
        end
    end

    // Local registers, returned to reset by hardware, init and global disable
    always_ff @(posedge clk)
    begin
        if (!rst_n || (ce && local_clr))
        begin
            tpr_r <= 8'h00;
            ldr_r <= 8'h00;
            icr_lo_r <= 32'h0000_0000;
            icr_hi_r <= 32'h0000_0000;
            tinit_r <= 32'h0000_0000;
            tdiv_r <= 4'h0;
            dfr_r <= LIC_DFR_RST;
            svr_r <= LIC_SVR_RST;
        end
        else if (ce && reg_wr)
        begin
            case (off)
                LIC_OFF_TPR: tpr_r <= mem_wdata[7:0];
                LIC_OFF_LDR: ldr_r <= mem_wdata[31:24];
                LIC_OFF_DFR: dfr_r <= mem_wdata[31:28];
                LIC_OFF_SVR: svr_r <= mem_wdata[8:0];
                LIC_OFF_ICR_LO: icr_lo_r <= mem_wdata;
                LIC_OFF_ICR_HI: icr_hi_r <= mem_wdata;
                LIC_OFF_TINIT: tinit_r <= mem_wdata;
                LIC_OFF_TDIV: tdiv_r <= mem_wdata[3:0];
                default: tpr_r <= tpr_r;
            endcase
        end
    end

    // Vector table; while soft-disabled masks stay set whatever is written
    always_ff @(posedge clk)
    begin
        if (!rst_n || (ce && (local_clr || soft_dis_evt)))
        begin
            for (int i = 0; i < LIC_LVT_N; i++)
                lvt_r[i] <= (!rst_n || local_clr) ? LIC_LVT_RST
                          : (lvt_r[i] | LIC_LVT_RST);
        end
        else if (ce && reg_wr && lvt_hit)
        begin
            lvt_r[lvt_idx] <= {mem_wdata[LIC_LVT_MASK_BIT] || !sw_en,
                               mem_wdata[15:0]};
        end
    end

    // Timer count; divider is stored but counting runs at the core rate
    always_ff @(posedge clk)
    begin
        if (!rst_n || (ce && local_clr))
            tcur_r <= 32'h0000_0000;
        else if (ce)
        begin
            if (reg_wr && (off == LIC_OFF_TINIT))
                tcur_r <= mem_wdata;
            else if (tcur_r != 32'h0000_0000)
                tcur_r <= tcur_r - 32'h0000_0001;
        end
    end

    // Answers to the core: model port, memory port, messages, delivery
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            msr_rdata <= 64'h0000_0000_0000_0000;
            msr_ack <= 1'b0;
            msr_fault <= 1'b0;
            reg_rdata_r <= 32'h0000_0000;
            vec_rd_r <= 1'b0;
            mem_rvalid <= 1'b0;
            init_prev_r <= 1'b1;
            core_init <= 1'b0;
            core_nmi <= 1'b0;
            core_startup <= 1'b0;
            core_stop_clock <= 1'b0;
            lvt_deliver <= 6'h00;
        end
        else if (ce)
        begin
            msr_ack <= run && (msr_wr || msr_rd) && !msr_bad;
            msr_fault <= msr_bad;
            if (run && msr_rd && msr_here)
                msr_rdata <= {28'h000_0000, base_r, en_r, 2'b00, bsp_r, 8'h00};
            if (reg_rd)
                reg_rdata_r <= rd_val;
            vec_rd_r <= reg_rd && vec_hit;
            mem_rvalid <= reg_rd;
            init_prev_r <= init_s;
            core_init <= init_evt;
            core_nmi <= run && en_r && nmi_msg;
            core_startup <= run && en_r && startup_msg && !bsp_r;
            // Older-generation secondary processors ignore stop-clock
            core_stop_clock <= run && en_r && !stop_s && (bsp_r || gen_new_r);
            lvt_deliver <= run ? (lvt_src & lvt_open & lvt_allow) : 6'h00;
        end
    end

    assign mem_hit = blk_hit;
    assign mem_rdata = vec_rd_r ? vec_rdata : reg_rdata_r;
    assign ident_feature_edx = {22'h00_0000, en_r, 9'h000};
    assign ident_initial_id = init_id_r;
    assign arbitration_id_reg = arb_r;

endmodule : lic_core
`default_nettype wire

// file: lic_pkg.sv
`default_nettype none
package lic_pkg;

    // Model-specific base register
    localparam logic [31:0] LIC_BASE_MSR_ADDR = 32'h0000_001b;
    localparam int LIC_BSP_BIT = 8;
    localparam int LIC_EN_BIT = 11;
    localparam int LIC_BASE_LSB = 12;
    localparam int LIC_BASE_MSB = 35;
    localparam logic [23:0] LIC_BASE_RST = 24'h0f_ee00;
    localparam logic [7:0] LIC_PHYS_WIDTH_DFLT = 8'h24;
    localparam logic [63:0] LIC_RSVD_FIXED = 64'hffff_fff0_0000_06ff;

    // Identification instruction, leaf 1
    localparam int LIC_PRESENT_BIT = 9;

    // Controller ID field
    localparam int LIC_ID_LSB = 24;
    localparam logic [7:0] LIC_ID_MASK_OLD = 8'h0f;
    localparam logic [7:0] LIC_ID_MASK_NEW = 8'hff;

    // Register block offsets
    localparam logic [11:0] LIC_OFF_ID = 12'h020;
    localparam logic [11:0] LIC_OFF_VER = 12'h030;
    localparam logic [11:0] LIC_OFF_TPR = 12'h080;
    localparam logic [11:0] LIC_OFF_LDR = 12'h0d0;
    localparam logic [11:0] LIC_OFF_DFR = 12'h0e0;
    localparam logic [11:0] LIC_OFF_SVR = 12'h0f0;
    localparam logic [11:0] LIC_OFF_VEC_FIRST = 12'h100;
    localparam logic [11:0] LIC_OFF_VEC_END = 12'h280;
    localparam logic [11:0] LIC_OFF_ICR_LO = 12'h300;
    localparam logic [11:0] LIC_OFF_ICR_HI = 12'h310;
    localparam logic [11:0] LIC_OFF_LVT_FIRST = 12'h320;
    localparam logic [11:0] LIC_OFF_LVT_LAST = 12'h370;
    localparam logic [11:0] LIC_OFF_TINIT = 12'h380;
    localparam logic [11:0] LIC_OFF_TCUR = 12'h390;
    localparam logic [11:0] LIC_OFF_TDIV = 12'h3e0;

    // Reset values and fields
    localparam logic [8:0] LIC_SVR_RST = 9'h0ff;
    localparam int LIC_SVR_EN_BIT = 8;
    localparam logic [3:0] LIC_DFR_RST = 4'hf;
    localparam logic [27:0] LIC_DFR_RO_ONES = 28'hfff_ffff;
    localparam int LIC_LVT_N = 6;
    localparam int LIC_LVT_MASK_BIT = 16;
    localparam logic [16:0] LIC_LVT_RST = 17'h1_0000;
    localparam logic [2:0] LIC_LVT_IDX_BIAS = 3'h2;
    localparam logic [7:0] LIC_MAX_LVT = 8'h05;
    localparam logic [5:0] LIC_LVT_LOCKED_OK = 6'h06;
    localparam int LIC_VEC_WORDS = 24;
    localparam logic [4:0] LIC_VEC_IDX_BIAS = 5'h10;

    typedef enum logic {LIC_PH_CAPTURE, LIC_PH_RUN} lic_phase_e;

    function automatic logic [63:0] lic_rsvd_mask(input logic [7:0] width);
        logic [63:0] m;
        m = LIC_RSVD_FIXED;
        for (int i = LIC_BASE_LSB; i <= LIC_BASE_MSB; i++)
        begin
            if (i >= int'(width))
                m[i] = 1'b1;
        end
        return m;
    endfunction : lic_rsvd_mask

    function automatic logic [7:0] lic_id_mask(input logic gen_new);
        return gen_new ? LIC_ID_MASK_NEW : LIC_ID_MASK_OLD;
    endfunction : lic_id_mask

endpackage : lic_pkg
`default_nettype wire

// file: lic_sync.sv
`timescale 1ns/100ps
`default_nettype none
module lic_sync #(
    parameter int W = 1
) (
    input wire logic clk, // Core clock
    input wire logic ce, // Clock enable
    input wire logic [W-1:0] d, // Asynchronous inputs
    output logic [W-1:0] q // Synchronised copies
);
    logic [W-1:0] meta_r;

    // No reset, so straps are already valid when reset releases
    always_ff @(posedge clk)
    begin
        if (ce)
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : lic_sync
`default_nettype wire

// file: lic_vec_mem.sv
`timescale 1ns/100ps
`default_nettype none
module lic_vec_mem
    import lic_pkg::*;
(
    input wire logic clk, // Core clock
    input wire logic rst_n, // Synchronous reset
    input wire logic ce, // Clock enable
    input wire logic clr, // Return to power-up state
    input wire logic wr_en, // Hardware write strobe
    input wire logic [4:0] wr_idx, // Word written
    input wire logic [31:0] wr_data, // Word value
    input wire logic [4:0] rd_idx, // Word read
    output logic [31:0] rd_data // Registered read data
);
    logic [31:0] mem_r [0:LIC_VEC_WORDS-1];
    wire wr_ok = wr_en && (int'(wr_idx) < LIC_VEC_WORDS);
    wire rd_ok = int'(rd_idx) < LIC_VEC_WORDS;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < LIC_VEC_WORDS; i++)
                mem_r[i] <= 32'h0000_0000;
            rd_data <= 32'h0000_0000;
        end
        else if (ce)
        begin
            if (clr)
            begin
                for (int i = 0; i < LIC_VEC_WORDS; i++)
                    mem_r[i] <= 32'h0000_0000;
            end
            else if (wr_ok)
                mem_r[wr_idx] <= wr_data;
            rd_data <= (clr || !rd_ok) ? 32'h0000_0000 : mem_r[rd_idx];
        end
    end
endmodule : lic_vec_mem
`default_nettype wire

// file: lic_msg_agent.sv
`timescale 1ns/100ps
`default_nettype none
module lic_msg_agent (
    input wire logic clk, // Core clock
    input wire logic go, // Send one message
    input wire logic [1:0] kind, // 0 init, 1 nmi, 2 startup
    input wire logic quiet, // Enable is being cleared
    output logic init_msg, // Init pulse
    output logic nmi_msg, // Non-maskable pulse
    output logic startup_msg // Startup pulse
);
    // Holding off during a disable keeps a message from racing it
    wire send = go && !quiet;
    always @(posedge clk)
    begin
        init_msg <= send && kind == 2'h0;
        nmi_msg <= send && kind == 2'h1;
        startup_msg <= send && kind == 2'h2;
    end
endmodule : lic_msg_agent
`default_nettype wire

// file: lic_core_sva.sv
`timescale 1ns/100ps
`default_nettype none
module lic_core_sva (
    input wire logic clk, // Core clock
    input wire logic rst_n, // Reset
    input wire logic ce, // Clock enable
    input wire logic bus_gen_new, // Bus generation
    input wire logic msr_wr, // Write strobe
    input wire logic msr_rd, // Read strobe
    input wire logic [31:0] msr_addr, // Address
    input wire logic [63:0] msr_wdata, // Write data
    input wire logic [63:0] msr_rdata, // Read data
    input wire logic msr_ack, // Done
    input wire logic msr_fault, // Refused
    input wire logic mem_req, // Memory request
    input wire logic mem_we, // Memory write
    input wire logic mem_hit, // Claimed
    input wire logic mem_rvalid, // Read valid
    input wire logic nmi_msg, // Message in
    input wire logic core_nmi, // Message out
    input wire logic [31:0] ident_feature_edx, // Flags
    input wire logic [7:0] ident_initial_id, // Initial ID
    input wire logic [7:0] arbitration_id_reg // Arbitration ID
);
    logic [1:0] up_r;
    // First edge after release only captures straps
    wire live = up_r != 2'h0;
    wire steady = up_r == 2'h2;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            up_r <= 2'h0;
        else if (ce && !steady)
            up_r <= up_r + 2'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    present_flag_a: assert property ((ident_feature_edx & ~32'h200) == 32'h0)
        else $error("flags beyond presence bit");
    flag_match_a: assert property (msr_ack && $past(msr_rd && !msr_wr)
        |-> msr_rdata[11] == ident_feature_edx[9]) else $error("presence differs from enable");
    hit_enable_a: assert property (mem_hit |-> mem_req && ident_feature_edx[9])
        else $error("hit while disabled");
    rsvd_fault_a: assert property (live && msr_wr && msr_addr == 32'h1b
        && msr_wdata[7:0] != 8'h0 |=> msr_fault && !msr_ack) else $error("reserved write taken");
    rdata_rsvd_a: assert property (msr_rdata[63:36] == 28'h0 && msr_rdata[10:9] == 2'h0
        && msr_rdata[7:0] == 8'h0) else $error("reserved bits read nonzero");
    read_answer_a: assert property (live && mem_req && !mem_we && mem_hit |=> mem_rvalid)
        else $error("read hit unanswered");
    rvalid_cause_a: assert property (mem_rvalid |-> $past(mem_req && !mem_we && mem_hit))
        else $error("read valid without hit");
    nmi_pass_a: assert property (live && nmi_msg && ident_feature_edx[9] |=> core_nmi)
        else $error("nmi not passed");
    nmi_cause_a: assert property (core_nmi |-> $past(nmi_msg))
        else $error("nmi without message");
    id_hold_a: assert property (steady |-> $stable(ident_initial_id))
        else $error("initial id changed");
    arb_load_a: assert property (steady |-> arbitration_id_reg == ident_initial_id)
        else $error("arbitration id differs");
    id_width_a: assert property (steady && !bus_gen_new |-> ident_initial_id[7:4] == 4'h0)
        else $error("old bus id too wide");
    msr_seen_c: cover property (msr_ack);
    fault_seen_c: cover property (msr_fault);
    read_seen_c: cover property (mem_rvalid);
endmodule : lic_core_sva
bind lic_core lic_core_sva u_lic_core_sva (.*);
`default_nettype wire

// file: lic_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
module lic_core_tb;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, boot_strap = 1'b1, controller_strap_pin = 1'b1;
    logic bus_gen_new = 1'b1, init_pin_n = 1'b1, stop_clock_pin_n = 1'b1, phys_leaf_sup = 1'b1;
    logic local_int_pin_0 = 1'b0, local_int_pin_1 = 1'b0, msr_wr = 1'b0, msr_rd = 1'b0;
    logic mem_req = 1'b0, mem_we = 1'b0, accept_wr = 1'b0, therm_evt = 1'b0, perf_evt = 1'b0;
    logic err_evt = 1'b0, go = 1'b0, quiet = 1'b0;
    logic [1:0] kind = 2'h0;
    logic [4:0] accept_idx = 5'h10;
    logic [7:0] id_pins = 8'ha5, phys_leaf_width = 8'h20;
    logic [31:0] msr_addr = 32'h0, mem_wdata = 32'h0, accept_data = 32'h8;
    logic [35:0] mem_addr = 36'h0;
    logic [63:0] msr_wdata = 64'h0, msr_rdata;
    logic [31:0] mem_rdata, ident_feature_edx;
    logic [7:0] ident_initial_id, arbitration_id_reg;
    logic [5:0] lvt_deliver;
    logic msr_ack, msr_fault, mem_hit, mem_rvalid, core_init, core_nmi, core_startup;
    logic core_stop_clock, init_msg, nmi_msg, startup_msg;
    logic [11:0] zoff [11] = '{12'h080, 12'h0d0, 12'h100, 12'h180, 12'h200, 12'h300,
        12'h310, 12'h380, 12'h390, 12'h3e0, 12'h3f0};
    localparam logic [35:0] B0 = 36'h0_fee0_0000;
    localparam logic [35:0] B1 = 36'h0_1234_5000;
    int bad_count = 0, comparisons = 0;
    lic_core u_lic_core (.*);
    lic_msg_agent u_lic_msg_agent (.*);
    initial
    begin
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask : tick
    task automatic close_out();
        if (bad_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out
    task automatic do_reset();
        logic [7:0] id;
        id = bus_gen_new ? id_pins : {4'h0, id_pins[3:0]};
        rst_n = 1'b0;
        tick(16);
        rst_n = 1'b1;
        tick(1);
        chk(ident_initial_id, id);
        chk(arbitration_id_reg, id);
        chk(ident_feature_edx, 32'h200);
    endtask : do_reset
    // Answer is a one-cycle pulse, so it is sampled in that cycle only
    task automatic msr(input logic w, input logic [31:0] a, input logic [63:0] d,
        input logic f, input logic [63:0] e);
        msr_wr = w;
        msr_rd = !w;
        msr_addr = a;
        msr_wdata = d;
        tick(1);
        msr_wr = 1'b0;
        msr_rd = 1'b0;
        chk(msr_fault, f);
        chk(msr_ack, !f);
        if (!w && !f)
            chk(msr_rdata, e);
        tick(1);
    endtask : msr
    task automatic mem(input logic w, input logic [35:0] a, input logic [31:0] d, input logic h);
        mem_req = 1'b1;
        mem_we = w;
        mem_addr = a;
        mem_wdata = d;
        #1;
        chk(mem_hit, h);
        tick(1);
        mem_req = 1'b0;
        chk(mem_rvalid, !w && h);
        if (!w && h)
            chk(mem_rdata, d);
        tick(1);
    endtask : mem
    task automatic msg(input logic [1:0] k, input logic [2:0] e);
        kind = k;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        tick(1);
        chk({core_init, core_nmi, core_startup}, e);
    endtask : msg
    initial
    begin
        do_reset();
        msr(1'b0, 32'h1b, 64'h0, 1'b0, 64'h0_fee0_0900);
        mem(1'b0, B0 + 36'h0f0, 32'hff, 1'b1);
        mem(1'b0, B0 + 36'h0e0, 32'hffff_ffff, 1'b1);
        mem(1'b0, B0 + 36'h020, 32'ha500_0000, 1'b1);
        mem(1'b0, B0 + 36'h030, 32'h0005_0015, 1'b1);
        for (int i = 0; i < 6; i++)
            mem(1'b0, B0 + 36'h320 + 36'(i * 16), 32'h1_0000, 1'b1);
        foreach (zoff[i])
            mem(1'b0, B0 + {24'h0, zoff[i]}, 32'h0, 1'b1);
        msr(1'b1, 32'h1b, 64'h0_fee0_0901, 1'b1, 64'h0);
        msr(1'b1, 32'h1b, 64'h0_fee0_0d00, 1'b1, 64'h0);
        msr(1'b1, 32'h1b, 64'h1_fee0_0900, 1'b1, 64'h0);
        msr(1'b0, 32'h1c, 64'h0, 1'b1, 64'h0);
        msr(1'b1, 32'h1b, 64'h0_1234_5900, 1'b0, 64'h0);
        mem(1'b0, B1 + 36'h0f0, 32'hff, 1'b1);
        mem(1'b0, B0 + 36'h0f0, 32'h0, 1'b0);
        msr(1'b0, 32'h1b, 64'h0, 1'b0, 64'h0_1234_5900);
        mem(1'b1, B1 + 36'h0f0, 32'h1ff, 1'b1);
        mem(1'b1, B1 + 36'h330, 32'h0, 1'b1);
        mem(1'b0, B1 + 36'h330, 32'h0, 1'b1);
        mem(1'b1, B1 + 36'h0f0, 32'h0ff, 1'b1);
        mem(1'b0, B1 + 36'h330, 32'h1_0000, 1'b1);
        mem(1'b1, B1 + 36'h330, 32'h0, 1'b1);
        mem(1'b0, B1 + 36'h330, 32'h1_0000, 1'b1);
        mem(1'b1, B1 + 36'h0f0, 32'h1ff, 1'b1);
        mem(1'b1, B1 + 36'h330, 32'h0, 1'b1);
        {therm_evt, perf_evt, err_evt} = 3'h7;
        tick(1);
        {therm_evt, perf_evt, err_evt} = 3'h0;
        chk(lvt_deliver, 6'h02);
        mem(1'b1, B1 + 36'h320, 32'h0, 1'b1);
        mem(1'b1, B1 + 36'h380, 32'h3, 1'b1);
        tick(2);
        chk(lvt_deliver, 6'h01);
        accept_wr = 1'b1;
        tick(1);
        accept_wr = 1'b0;
        mem(1'b0, B1 + 36'h200, 32'h8, 1'b1);
        quiet = 1'b1;
        msr(1'b1, 32'h1b, 64'h0_1234_5100, 1'b0, 64'h0);
        chk(ident_feature_edx, 32'h0);
        mem(1'b0, B1 + 36'h0f0, 32'h0, 1'b0);
        msr(1'b1, 32'h1b, 64'h0_1234_5900, 1'b0, 64'h0);
        quiet = 1'b0;
        mem(1'b0, B1 + 36'h200, 32'h0, 1'b1);
        mem(1'b0, B1 + 36'h330, 32'h1_0000, 1'b1);
        msg(2'h1, 3'h2);
        msg(2'h2, 3'h0);
        // Clock enable low must freeze the write
        ce = 1'b0;
        mem(1'b1, B1 + 36'h0f0, 32'h1ff, 1'b1);
        ce = 1'b1;
        mem(1'b0, B1 + 36'h0f0, 32'hff, 1'b1);
        mem(1'b1, B1 + 36'h0f0, 32'h1ff, 1'b1);
        msg(2'h0, 3'h4);
        mem(1'b0, B1 + 36'h0f0, 32'hff, 1'b1);
        mem(1'b1, B1 + 36'h0f0, 32'h1ff, 1'b1);
        init_pin_n = 1'b0;
        tick(4);
        init_pin_n = 1'b1;
        tick(4);
        mem(1'b0, B1 + 36'h0f0, 32'hff, 1'b1);
        mem(1'b0, B1 + 36'h020, 32'ha500_0000, 1'b1);
        stop_clock_pin_n = 1'b0;
        tick(4);
        chk(core_stop_clock, 1'b1);
        stop_clock_pin_n = 1'b1;
        // Older bus, secondary processor, width leaf absent
        bus_gen_new = 1'b0;
        boot_strap = 1'b0;
        phys_leaf_sup = 1'b0;
        do_reset();
        msr(1'b0, 32'h1b, 64'h0, 1'b0, 64'h0_fee0_0800);
        msr(1'b1, 32'h1b, 64'h1_fee0_0800, 1'b0, 64'h0);
        msg(2'h2, 3'h1);
        stop_clock_pin_n = 1'b0;
        tick(5);
        chk(core_stop_clock, 1'b0);
        stop_clock_pin_n = 1'b1;
        msr(1'b1, 32'h1b, 64'h1_fee0_0000, 1'b0, 64'h0);
        msr(1'b1, 32'h1b, 64'h1_fee0_0800, 1'b0, 64'h0);
        msr(1'b0, 32'h1b, 64'h0, 1'b0, 64'h1_fee0_0000);
        close_out();
    end
endmodule : lic_core_tb
`default_nettype wire
